// [timer_gate_control.sv]
/*
 * Timer gate control with APB register access and event interrupt.
 * Assumes an APB master on CLK_SYS_I and inputs synchronous to it,
 * except comparator outputs which may be synchronised inside.
 */
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module timer_gate_control
(
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic GATE_PIN_I,
    input wire logic TIMER2_OVF_I,
    input wire logic CMP1_OUT_I,
    input wire logic CMP2_OUT_I,
    output logic COUNT_EN_O,
    output logic IRQ_O
);
    typedef enum logic [1:0]
    {
        SP_IDLE,
        SP_WAIT,
        SP_PULSE
    } sp_state_t;

    gate_if g();

    logic [7:0] gcon_q;
    logic [2:0] ctrl_q;
    logic [1:0] ien_q;
    logic [1:0] stat_q;
    logic [1:0] ev_set;
    sp_state_t sp_q;
    logic gv_q;
    logic tog_q;
    logic after_tog;
    logic rise;
    logic sp_gate;
    logic final_gate;
    logic go_done;
    logic wr;
    logic rd;
    logic go_wr;
    logic [31:0] rdata;
    logic addr_ok;

    // ------------------------------------------------------------
    // Gate source path
    // ------------------------------------------------------------
    assign g.src_sel = gcon_q[gate_pkg::SS_LSB +: 2];
    assign g.cmp1_sync_en = ctrl_q[gate_pkg::C1SYNC_BIT];
    assign g.cmp2_sync_en = ctrl_q[gate_pkg::C2SYNC_BIT];
    assign g.polarity = gcon_q[gate_pkg::POL_BIT];
    assign g.gate_pin = GATE_PIN_I;
    assign g.ovf = TIMER2_OVF_I;
    assign g.cmp1 = CMP1_OUT_I;
    assign g.cmp2 = CMP2_OUT_I;

    gate_src u_src
    (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .g(g)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    assign rd = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign addr_ok = hit(PADDR_I, gate_pkg::GCON_ADDR) || hit(PADDR_I, gate_pkg::CTRL_ADDR)
        || hit(PADDR_I, gate_pkg::STAT_ADDR) || hit(PADDR_I, gate_pkg::IEN_ADDR)
        || hit(PADDR_I, gate_pkg::ICLR_ADDR);
    assign go_wr = wr && hit(PADDR_I, gate_pkg::GCON_ADDR) && PWDATA_I[gate_pkg::GO_BIT];

    // ------------------------------------------------------------
    // Toggle flip-flop and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            gv_q <= 1'b1;
        else
            gv_q <= g.gate_val;
    end

    assign rise = g.gate_val && !gv_q;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            tog_q <= 1'b0;
        else if (!gcon_q[gate_pkg::TM_BIT])
            tog_q <= 1'b0;
        else if (rise)
            tog_q <= !tog_q;
    end

    assign after_tog = gcon_q[gate_pkg::TM_BIT] ? tog_q : g.gate_val;

    // ------------------------------------------------------------
    // Single-pulse acquisition
    // ------------------------------------------------------------
    logic at_q;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            at_q <= 1'b0;
        else
            at_q <= after_tog;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            sp_q <= SP_IDLE;
        else if (!gcon_q[gate_pkg::SPM_BIT])
            sp_q <= SP_IDLE;
        else
        begin
            case (sp_q)
                SP_IDLE:
                    if (go_wr)
                        sp_q <= SP_WAIT;
                SP_WAIT:
                    if (after_tog && !at_q)
                        sp_q <= SP_PULSE;
                SP_PULSE:
                    if (!after_tog)
                        sp_q <= SP_IDLE;
                default:
                    sp_q <= SP_IDLE;
            endcase
        end
    end

    assign go_done = (sp_q != SP_IDLE);
    assign sp_gate = (sp_q == SP_PULSE) && after_tog;
    assign final_gate = gcon_q[gate_pkg::SPM_BIT] ? sp_gate : after_tog;

    // ------------------------------------------------------------
    // Counter enable
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            COUNT_EN_O <= 1'b0;
        else if (!ctrl_q[gate_pkg::RUN_BIT])
            COUNT_EN_O <= 1'b0;
        else if (!gcon_q[gate_pkg::GE_BIT])
            COUNT_EN_O <= 1'b1;
        else
            COUNT_EN_O <= final_gate;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            gcon_q <= gate_pkg::GCON_RST;
        else if (wr && hit(PADDR_I, gate_pkg::GCON_ADDR))
        begin
            gcon_q[7:4] <= PWDATA_I[7:4];
            gcon_q[1:0] <= PWDATA_I[1:0];
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            ctrl_q <= gate_pkg::CTRL_RST;
        else if (wr && hit(PADDR_I, gate_pkg::CTRL_ADDR))
            ctrl_q <= PWDATA_I[2:0];
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            ien_q <= gate_pkg::IEN_RST;
        else if (wr && hit(PADDR_I, gate_pkg::IEN_ADDR))
            ien_q <= PWDATA_I[1:0];
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    assign ev_set[gate_pkg::EV_DONE_BIT] = (sp_q == SP_PULSE) && !after_tog
        && gcon_q[gate_pkg::SPM_BIT];
    assign ev_set[gate_pkg::EV_RISE_BIT] = rise;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            stat_q <= 2'h0;
        else if (wr && hit(PADDR_I, gate_pkg::ICLR_ADDR))
            stat_q <= (stat_q & ~PWDATA_I[1:0]) | ev_set;
        else
            stat_q <= stat_q | ev_set;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
            IRQ_O <= 1'b0;
        else
            IRQ_O <= |(stat_q & ien_q);
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb
    begin
        rdata = 32'h0;
        if (hit(PADDR_I, gate_pkg::GCON_ADDR))
        begin
            rdata[7:4] = gcon_q[7:4];
            rdata[gate_pkg::GO_BIT] = go_done;
            rdata[gate_pkg::VAL_BIT] = g.gate_val;
            rdata[1:0] = gcon_q[1:0];
        end
        else if (hit(PADDR_I, gate_pkg::CTRL_ADDR))
            rdata[2:0] = ctrl_q;
        else if (hit(PADDR_I, gate_pkg::STAT_ADDR))
            rdata[1:0] = stat_q;
        else if (hit(PADDR_I, gate_pkg::IEN_ADDR))
            rdata[1:0] = ien_q;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
        begin
            PRDATA_O <= 32'h0;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            if (rd)
                PRDATA_O <= rdata;
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !addr_ok;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_run_off;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        !ctrl_q[gate_pkg::RUN_BIT] |=> !COUNT_EN_O;
    endproperty
    a_run_off: assert property (p_run_off) else $error("count while stopped");

    property p_free;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        ctrl_q[gate_pkg::RUN_BIT] && !gcon_q[gate_pkg::GE_BIT] |=> COUNT_EN_O;
    endproperty
    a_free: assert property (p_free) else $error("free count missing");

    property p_pol;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        g.src_sel == 2'h0 |-> g.gate_val == (GATE_PIN_I ~^ gcon_q[gate_pkg::POL_BIT]);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity wrong");

    property p_ovf;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        g.src_sel == 2'h1 && gcon_q[gate_pkg::POL_BIT] |-> g.gate_val == TIMER2_OVF_I;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow source wrong");

    property p_c2sync;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        g.src_sel == 2'h3 && ctrl_q[gate_pkg::C2SYNC_BIT] && gcon_q[gate_pkg::POL_BIT]
            && $stable(g.src_sel) && $stable(ctrl_q) && $stable(gcon_q)
            |-> g.gate_val == $past(CMP2_OUT_I, 2);
    endproperty
    a_c2sync: assert property (p_c2sync) else $error("cmp2 sync wrong");

    property p_c1dir;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        g.src_sel == 2'h2 && !ctrl_q[gate_pkg::C1SYNC_BIT] && gcon_q[gate_pkg::POL_BIT]
            |-> g.gate_val == CMP1_OUT_I;
    endproperty
    a_c1dir: assert property (p_c1dir) else $error("cmp1 direct wrong");

    property p_go;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        go_wr && gcon_q[gate_pkg::SPM_BIT] && PWDATA_I[gate_pkg::SPM_BIT] |=> go_done;
    endproperty
    a_go: assert property (p_go) else $error("go not armed");

    property p_tog;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        gcon_q[gate_pkg::TM_BIT] && $past(gcon_q[gate_pkg::TM_BIT]) && $rose(g.gate_val)
            |=> tog_q != $past(tog_q);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle missed");

    property p_tclr;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        !gcon_q[gate_pkg::TM_BIT] |=> !tog_q;
    endproperty
    a_tclr: assert property (p_tclr) else $error("toggle not cleared");

    property p_val_ge;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        rd && hit(PADDR_I, gate_pkg::GCON_ADDR) |=> PRDATA_O[gate_pkg::VAL_BIT] == $past(g.gate_val);
    endproperty
    a_val_ge: assert property (p_val_ge) else $error("gate value read wrong");

    property p_gated;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        ctrl_q[gate_pkg::RUN_BIT] && gcon_q[gate_pkg::GE_BIT] && !gcon_q[gate_pkg::TM_BIT]
            && !gcon_q[gate_pkg::SPM_BIT] |=> COUNT_EN_O == $past(g.gate_val);
    endproperty
    a_gated: assert property (p_gated) else $error("gated count wrong");

    property p_done;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        sp_q == SP_PULSE && !after_tog && gcon_q[gate_pkg::SPM_BIT]
            |=> !go_done && stat_q[gate_pkg::EV_DONE_BIT];
    endproperty
    a_done: assert property (p_done) else $error("single pulse not done");

    property p_c2dir;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        g.src_sel == 2'h3 && !ctrl_q[gate_pkg::C2SYNC_BIT] && !gcon_q[gate_pkg::POL_BIT]
            |-> g.gate_val == !CMP2_OUT_I;
    endproperty
    a_c2dir: assert property (p_c2dir) else $error("cmp2 direct wrong");
endmodule

// [gate_pkg.sv]
/*
 * Constants for the timer gate control block: register map, field
 * positions, reset values and the gate source encoding.
 * Assumes an APB slave with 32-bit data and one word per register.
 */
//
// Notes on behaviour
// - Gate enable clear and running: count freely; set and running: gate decides counting.
// - Polarity one counts while gate high; zero counts while gate low.
// - Go/done reads one while armed, waiting or in the pulse, zero when done or idle.
// - Gate value shows the gate after source selection and polarity.
// - Gate value tracks the gate even when gate enable is clear.
// - Select 11 routes comparator 2, select 10 routes comparator 1.
// - Select 01 routes second timer overflow, select 00 the gate pin.
// - Each comparator gate source is usable direct or synchronised.
//
package gate_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] GCON_ADDR = 8'h00;
    localparam logic [7:0] CTRL_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [7:0] IEN_ADDR = 8'h0c;
    localparam logic [7:0] ICLR_ADDR = 8'h10;

    // ------------------------------------------------------------
    // Gate control fields
    // ------------------------------------------------------------
    localparam int GE_BIT = 7;
    localparam int POL_BIT = 6;
    localparam int TM_BIT = 5;
    localparam int SPM_BIT = 4;
    localparam int GO_BIT = 3;
    localparam int VAL_BIT = 2;
    localparam int SS_LSB = 0;

    // ------------------------------------------------------------
    // Auxiliary control fields
    // ------------------------------------------------------------
    localparam int RUN_BIT = 0;
    localparam int C1SYNC_BIT = 1;
    localparam int C2SYNC_BIT = 2;

    // ------------------------------------------------------------
    // Event bits
    // ------------------------------------------------------------
    localparam int EV_DONE_BIT = 0;
    localparam int EV_RISE_BIT = 1;
    localparam int EV_W = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GCON_RST = 8'h00;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [1:0] IEN_RST = 2'h0;

    // ------------------------------------------------------------
    // Gate source encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SRC_PIN = 2'h0,
        SRC_OVF = 2'h1,
        SRC_CMP1 = 2'h2,
        SRC_CMP2 = 2'h3
    } gate_src_t;

endpackage

// [gate_if.sv]
/*
 * Interface between the register file and the gate path.
 * Assumes both sides share CLK_SYS_I.
 */
`timescale 1ns/1ps
interface gate_if;
    logic [1:0] src_sel;
    logic cmp1_sync_en;
    logic cmp2_sync_en;
    logic polarity;
    logic gate_pin;
    logic ovf;
    logic cmp1;
    logic cmp2;
    logic gate_val;
    modport src
    (
        input src_sel, cmp1_sync_en, cmp2_sync_en, polarity, gate_pin, ovf, cmp1, cmp2,
        output gate_val
    );
    modport ctl
    (
        output src_sel, cmp1_sync_en, cmp2_sync_en, polarity, gate_pin, ovf, cmp1, cmp2,
        input gate_val
    );
endinterface

// [gate_src.sv]
/*
 * Gate source selection, optional comparator synchronisation and polarity.
 * Assumes all inputs are synchronous to CLK_SYS_I except the comparators.
 */
`timescale 1ns/1ps
module gate_src
(
    input wire logic clk_i,
    input wire logic nrst_i,
    gate_if.src g
);
    logic c1_m_q;
    logic c1_s_q;
    logic c2_m_q;
    logic c2_s_q;
    logic c1_eff;
    logic c2_eff;
    logic sel_raw;

    // ------------------------------------------------------------
    // Comparator synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            c1_m_q <= 1'b0;
            c1_s_q <= 1'b0;
            c2_m_q <= 1'b0;
            c2_s_q <= 1'b0;
        end
        else
        begin
            c1_m_q <= g.cmp1;
            c1_s_q <= c1_m_q;
            c2_m_q <= g.cmp2;
            c2_s_q <= c2_m_q;
        end
    end

    assign c1_eff = g.cmp1_sync_en ? c1_s_q : g.cmp1;
    assign c2_eff = g.cmp2_sync_en ? c2_s_q : g.cmp2;

    // ------------------------------------------------------------
    // Source mux and polarity
    // ------------------------------------------------------------
    always_comb
    begin
        case (gate_pkg::gate_src_t'(g.src_sel))
            gate_pkg::SRC_CMP2: sel_raw = c2_eff;
            gate_pkg::SRC_CMP1: sel_raw = c1_eff;
            gate_pkg::SRC_OVF: sel_raw = g.ovf;
            gate_pkg::SRC_PIN: sel_raw = g.gate_pin;
            default: sel_raw = g.gate_pin;
        endcase
    end

    assign g.gate_val = g.polarity ? sel_raw : ~sel_raw;
endmodule

// [gate_partner.sv]
/*
 * Far side of the gate block: gate pin, second timer overflow, two
 * comparators and the counter that obeys the count enable.
 * Assumes the bench drives the wanted source levels after a rising edge.
 */
`timescale 1ns/1ps
module gate_partner
(
    input wire logic clk_i,
    input wire logic [3:0] lvl_i,
    input wire logic count_en_i,
    output logic pin_o,
    output logic ovf_o,
    output logic cmp1_o,
    output logic cmp2_o,
    output logic [15:0] count_o
);
    // ------------------------------------------------------------
    // Sources
    // ------------------------------------------------------------
    assign pin_o = lvl_i[0];
    assign ovf_o = lvl_i[1];
    // Comparators are asynchronous to the core clock
    assign #1.3 cmp1_o = lvl_i[2];
    assign #1.3 cmp2_o = lvl_i[3];

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    initial count_o = 16'h0000;
    always @(posedge clk_i)
    begin
        if (count_en_i === 1'b1)
            count_o <= count_o + 16'h0001;
    end
endmodule

// [timer_gate_control_tb_top.sv]
/*
 * Self-checking bench for the timer gate control block.
 * Assumes an APB slave; the master waits for pready in the access phase.
 */
`timescale 1ns/1ps
module timer_gate_control_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] lvl = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, pin, ovf, cmp1, cmp2, count_en, irq;
    logic [15:0] cnt, c0;
    int fail_count = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    timer_gate_control dut
    (
        .CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .GATE_PIN_I(pin),
        .TIMER2_OVF_I(ovf), .CMP1_OUT_I(cmp1), .CMP2_OUT_I(cmp2),
        .COUNT_EN_O(count_en), .IRQ_O(irq)
    );

    gate_partner far
    (
        .clk_i(clk), .lvl_i(lvl), .count_en_i(count_en), .pin_o(pin),
        .ovf_o(ovf), .cmp1_o(cmp1), .cmp2_o(cmp2), .count_o(cnt)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task give_verdict;
        begin
            $display("checked %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked++;
            if (seen !== exp)
            begin
                fail_count++;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        begin
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1)
                @(posedge clk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wt;
        begin
            repeat (4) @(posedge clk);
            @(negedge clk);
        end
    endtask

    task setl(input logic [3:0] v);
        begin
            @(posedge clk);
            lvl <= v;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        begin
            chk("count_en_rst", count_en, 32'h0);
            chk("irq_rst", irq, 32'h0);
            apb(1'b0, gate_pkg::GCON_ADDR, 32'h0);
            chk("gcon_rst", rd, 32'h4);
            apb(1'b0, gate_pkg::STAT_ADDR, 32'h0);
            chk("stat_rst", rd, 32'h0);
            apb(1'b0, gate_pkg::IEN_ADDR, 32'h0);
            chk("ien_rst", rd, 32'h0);
        end
    endtask

    task t_run;
        begin
            apb(1'b1, gate_pkg::GCON_ADDR, 32'h80);
            wt;
            c0 = cnt;
            wt;
            chk("stopped_count", 32'(cnt - c0), 32'h0);
            chk("stopped_en", count_en, 32'h0);
            apb(1'b1, gate_pkg::CTRL_ADDR, 32'h1);
            apb(1'b1, gate_pkg::GCON_ADDR, 32'h0);
            wt;
            c0 = cnt;
            wt;
            chk("free_count", 32'(cnt - c0), 32'h4);
        end
    endtask

    task t_sources;
        logic [7:0] g;
        logic e;
        begin
            for (int c = 0; c < 2; c++)
                for (int s = 0; s < 4; s++)
                    for (int p = 0; p < 2; p++)
                        for (int v = 0; v < 2; v++)
                        begin
                            g = {1'b0, 1'(p), 4'h0, 2'(s)};
                            e = (v == p);
                            apb(1'b1, gate_pkg::CTRL_ADDR, c ? 32'h7 : 32'h1);
                            setl(4'(v) << s);
                            apb(1'b1, gate_pkg::GCON_ADDR, {24'h0, g});
                            wt;
                            apb(1'b0, gate_pkg::GCON_ADDR, 32'h0);
                            chk("gate_value", rd, {24'h0, g | {5'h0, e, 2'h0}});
                            chk("ungated_en", count_en, 32'h1);
                            apb(1'b1, gate_pkg::GCON_ADDR, {24'h0, g | 8'h80});
                            wt;
                            chk("gated_en", count_en, {31'h0, e});
                        end
        end
    endtask

    task pulse;
        begin
            setl(4'h1);
            wt;
            setl(4'h0);
            wt;
        end
    endtask

    task t_toggle;
        begin
            apb(1'b1, gate_pkg::CTRL_ADDR, 32'h1);
            setl(4'h0);
            apb(1'b1, gate_pkg::GCON_ADDR, 32'he0);
            wt;
            chk("tog_start", count_en, 32'h0);
            pulse;
            chk("tog_one", count_en, 32'h1);
            apb(1'b0, gate_pkg::GCON_ADDR, 32'h0);
            chk("tog_value", rd, 32'he0);
            pulse;
            chk("tog_two", count_en, 32'h0);
            pulse;
            apb(1'b1, gate_pkg::GCON_ADDR, 32'hc0);
            apb(1'b1, gate_pkg::GCON_ADDR, 32'he0);
            wt;
            chk("tog_cleared", count_en, 32'h0);
        end
    endtask

    task t_single;
        begin
            apb(1'b1, gate_pkg::GCON_ADDR, 32'hd0);
            apb(1'b1, gate_pkg::ICLR_ADDR, 32'h3);
            apb(1'b1, gate_pkg::GCON_ADDR, 32'hd8);
            wt;
            apb(1'b0, gate_pkg::GCON_ADDR, 32'h0);
            chk("armed", rd, 32'hd8);
            chk("armed_en", count_en, 32'h0);
            setl(4'h1);
            wt;
            chk("pulse_en", count_en, 32'h1);
            setl(4'h0);
            wt;
            chk("pulse_end", count_en, 32'h0);
            apb(1'b0, gate_pkg::GCON_ADDR, 32'h0);
            chk("done", rd, 32'hd0);
            apb(1'b0, gate_pkg::STAT_ADDR, 32'h0);
            chk("status", rd, 32'h3);
            chk("irq_masked", irq, 32'h0);
            apb(1'b1, gate_pkg::IEN_ADDR, 32'h1);
            wt;
            chk("irq_on", irq, 32'h1);
            setl(4'h1);
            wt;
            chk("no_rearm", count_en, 32'h0);
            setl(4'h0);
            apb(1'b1, gate_pkg::STAT_ADDR, 32'hffffffff);
            apb(1'b1, gate_pkg::ICLR_ADDR, 32'h1);
            wt;
            chk("irq_off", irq, 32'h0);
            apb(1'b0, gate_pkg::STAT_ADDR, 32'h0);
            chk("status_left", rd, 32'h2);
            apb(1'b0, gate_pkg::ICLR_ADDR, 32'h0);
            chk("clr_read", rd, 32'h0);
            apb(1'b0, 8'h14, 32'h0);
            chk("unmapped_err", er, 32'h1);
            chk("unmapped_data", rd, 32'h0);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        t_reset;
        t_run;
        t_sources;
        t_toggle;
        t_single;
        give_verdict;
    end

    initial
    begin
        #200000;
        fail_count++;
        give_verdict;
    end
endmodule
